// ==== hw/tcc_pkg.sv ====
// Constants for the timer capture/compare unit
package tcc_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [5:0] TCC_VAL_LOW_IDX  = 6'h15;
	localparam logic [5:0] TCC_VAL_HIGH_IDX = 6'h16;
	localparam logic [5:0] TCC_CONTROL_IDX  = 6'h17;
	localparam logic [5:0] TCC_FLAG_IDX     = 6'h18;
	localparam logic [5:0] TCC_PORT_IDX     = 6'h19;
	localparam int         TCC_ADDR_W       = 8;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int TCC_CTRL_MODE_LSB = 0;   // ccp_mode_select [3:0]
	localparam int TCC_CTRL_DUTY_LSB = 4;   // duty_low_bits [5:4]
	localparam int TCC_FLAG_BIT      = 0;   // ccp_event_flag, write 1 clears
	localparam int TCC_ENABLE_BIT    = 1;   // ccp_event_enable
	localparam int TCC_DIR0_BIT      = 0;   // port_b_direction bit 0
	localparam int TCC_DIR3_BIT      = 1;   // port_b_direction bit 3
	localparam int TCC_LAT0_BIT      = 2;   // port data latch bit 0
	localparam int TCC_LAT3_BIT      = 3;   // port data latch bit 3
	localparam int TCC_MAP_BIT       = 4;   // ccp_pin_map_bit

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [5:0] TCC_CONTROL_RST = 6'h00;
	localparam logic [4:0] TCC_PORT_RST    = 5'h03;   // both pins input
	localparam logic [3:0] TCC_PSC_RST     = 4'h0;

	// ---------------------------------------------------------------
	// Mode codes of ccp_mode_select
	// ---------------------------------------------------------------
	localparam logic [3:0] TCC_MODE_OFF      = 4'h0;
	localparam logic [3:0] TCC_MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] TCC_MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] TCC_MODE_CAP_4TH  = 4'h6;
	localparam logic [3:0] TCC_MODE_CAP_16TH = 4'h7;
	localparam logic [3:0] TCC_MODE_CMP_SET  = 4'h8;
	localparam logic [3:0] TCC_MODE_CMP_CLR  = 4'h9;
	localparam logic [3:0] TCC_MODE_CMP_FLAG = 4'hA;
	localparam logic [3:0] TCC_MODE_CMP_SPEC = 4'hB;

	// AXI responses
	localparam logic [1:0] TCC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] TCC_RESP_SLVERR = 2'h2;

endpackage : tcc_pkg

// ==== hw/tcc_unit.sv ====
// Timer capture/compare unit with AXI4-Lite register slave
// Functional notes
// - Capture copies full 16-bit timer one count into capture_compare_value.
// - Capture event: falling, rising, every 4th or 16th rising edge.
// - Each capture sets ccp_event_flag; only software clears it.
// - New capture overwrites old value; no overrun indication.
// - Driven pin level feeds the edge detector; port writes can capture.
// - ccp_pin_map_bit picks port B bit 0 or 3 and its direction bit.
// - Mode change may set the flag spuriously; software handles it.
// - Prescaler counter cleared while off or not in capture mode.
// - Switching between capture prescalers keeps the counter running.
// - Compare checks value against timer one on each timer update.
// - Match drives pin high, low or unchanged; sets flag same cycle.
// - Writing zero to control forces compare latch low, port latch kept.
// - Flag-only compare sets flag, leaves pin alone.
// - Special event resets timer one, starts conversion, no overflow flag.
`timescale 1ns/1ps

module tcc_unit
	import tcc_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	// AXI4-Lite write address and data
	input  wire logic                  s_axi_awvalid_i,
	output      logic                  s_axi_awready_o,
	input  wire logic [TCC_ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                  s_axi_wvalid_i,
	output      logic                  s_axi_wready_o,
	input  wire logic [31:0]           s_axi_wdata_i,
	input  wire logic [3:0]            s_axi_wstrb_i,
	// AXI4-Lite write response
	output      logic                  s_axi_bvalid_o,
	input  wire logic                  s_axi_bready_i,
	output      logic [1:0]            s_axi_bresp_o,
	// AXI4-Lite read
	input  wire logic                  s_axi_arvalid_i,
	output      logic                  s_axi_arready_o,
	input  wire logic [TCC_ADDR_W-1:0] s_axi_araddr_i,
	output      logic                  s_axi_rvalid_o,
	input  wire logic                  s_axi_rready_i,
	output      logic [31:0]           s_axi_rdata_o,
	output      logic [1:0]            s_axi_rresp_o,
	// Timer one interface
	input  wire logic [15:0]           timer_one_count_i,
	input  wire logic                  timer_update_i,
	output      logic                  timer_one_reset_o,
	// Converter trigger
	input  wire logic                  adc_enable_i,
	output      logic                  adc_start_o,
	// Port B pins 0 and 3 (index 0 is bit 0, index 1 is bit 3)
	input  wire logic [1:0]            port_pin_i,
	output      logic [1:0]            port_pin_o,
	output      logic [1:0]            port_pin_oe_o,
	// Status
	output      logic                  ccp_event_flag_o,
	output      logic                  ccp_event_enable_o,
	output      logic [1:0]            duty_low_bits_o
);

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [5:0]            control_r;
	logic [15:0]           value_r;
	logic                  flag_r;
	logic                  enable_r;
	logic [4:0]            port_r;
	logic                  cmp_latch_r;
	logic                  pin_prev_r;
	logic [3:0]            psc_r;
	logic                  aw_have_r;
	logic                  w_have_r;
	logic [TCC_ADDR_W-1:0] aw_addr_r;
	logic [31:0]           w_data_r;
	logic [3:0]            w_strb_r;
	logic                  bvalid_r;
	logic [1:0]            bresp_r;
	logic                  rvalid_r;
	logic [31:0]           rdata_r;
	logic [1:0]            rresp_r;
	logic                  trig_r;
	logic                  adc_r;

	logic [3:0]  mode;
	logic        is_capture;
	logic        is_compare;
	logic        pin_sel;
	logic        pin_level;
	logic        rise;
	logic        fall;
	logic        capture;
	logic        match;
	logic        wr_go;
	logic        wr_byte;
	logic [5:0]  wr_idx;
	logic [5:0]  rd_idx;
	logic        wr_ctrl;
	logic        wr_flag;
	logic [1:0]  dir_bits;
	logic [1:0]  lat_bits;
	logic [1:0]  drive_val;

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	assign mode       = control_r[TCC_CTRL_MODE_LSB +: 4];
	assign is_capture = (mode[3:2] == 2'b01);
	assign is_compare = (mode[3:2] == 2'b10);
	assign duty_low_bits_o = control_r[TCC_CTRL_DUTY_LSB +: 2];

	// ---------------------------------------------------------------
	// Pin mapping and drive
	// ---------------------------------------------------------------
	// Map bit selects which port B pin, and so which direction bit, rules
	assign pin_sel  = port_r[TCC_MAP_BIT];
	assign dir_bits = {port_r[TCC_DIR3_BIT], port_r[TCC_DIR0_BIT]};
	assign lat_bits = {port_r[TCC_LAT3_BIT], port_r[TCC_LAT0_BIT]};

	// Compare set/clear modes take the mapped pin from the compare latch, all other pins and modes from the port latch;
	// the port latch itself is never touched by the unit
	always_comb begin
		drive_val = lat_bits;
		if (mode == TCC_MODE_CMP_SET || mode == TCC_MODE_CMP_CLR) begin
			drive_val[pin_sel] = cmp_latch_r;
		end
	end

	assign port_pin_o    = drive_val;
	assign port_pin_oe_o = ~dir_bits;

	// An output pin is seen at its driven level, so a port latch write
	// can look like an edge to the capture logic
	assign pin_level = dir_bits[pin_sel] ? port_pin_i[pin_sel]
	                                     : drive_val[pin_sel];

	// ---------------------------------------------------------------
	// Edge detection and capture
	// ---------------------------------------------------------------
	assign rise = pin_level & ~pin_prev_r;
	assign fall = ~pin_level & pin_prev_r;

	always_comb begin
		unique case (mode)
			TCC_MODE_CAP_FALL: capture = fall;
			TCC_MODE_CAP_RISE: capture = rise;
			TCC_MODE_CAP_4TH:  capture = rise & (psc_r[1:0] == 2'h3);
			TCC_MODE_CAP_16TH: capture = rise & (psc_r == 4'hF);
			default:           capture = 1'b0;
		endcase
	end

	// Previous pin level for the edge detector
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pin_prev_r <= 1'b0;
		end else begin
			pin_prev_r <= pin_level;
		end
	end

	// Prescaler counts rising edges; held clear outside capture, but a
	// switch between two capture settings leaves it running
	always_ff @(posedge clk_i) begin
		if (reset_i || !is_capture) begin
			psc_r <= TCC_PSC_RST;
		end else if (rise) begin
			psc_r <= psc_r + 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// Compare
	// ---------------------------------------------------------------
	assign match = is_compare & timer_update_i
	             & (value_r == timer_one_count_i);

	// Compare output latch, forced low while the unit is off
	always_ff @(posedge clk_i) begin
		if (reset_i || mode == TCC_MODE_OFF) begin
			cmp_latch_r <= 1'b0;
		end else if (match && mode == TCC_MODE_CMP_SET) begin
			cmp_latch_r <= 1'b1;
		end else if (match && mode == TCC_MODE_CMP_CLR) begin
			cmp_latch_r <= 1'b0;
		end
	end

	// Special event: one-cycle timer reset and conversion start; the
	// overflow flag lives in the timer and sees no overflow here
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			trig_r <= 1'b0;
			adc_r  <= 1'b0;
		end else begin
			trig_r <= match & (mode == TCC_MODE_CMP_SPEC);
			adc_r  <= match & (mode == TCC_MODE_CMP_SPEC)
			        & adc_enable_i;
		end
	end

	assign timer_one_reset_o = trig_r;
	assign adc_start_o       = adc_r;

	// ---------------------------------------------------------------
	// AXI4-Lite write channel
	// ---------------------------------------------------------------
	assign s_axi_awready_o = ~aw_have_r & ~bvalid_r;
	assign s_axi_wready_o  = ~w_have_r & ~bvalid_r;
	assign wr_go   = aw_have_r & w_have_r & ~bvalid_r;
	assign wr_idx  = aw_addr_r[TCC_ADDR_W-1:2];
	assign wr_byte = wr_go & w_strb_r[0];   // Registers use the low lane
	assign wr_ctrl = wr_byte & (wr_idx == TCC_CONTROL_IDX);
	assign wr_flag = wr_byte & (wr_idx == TCC_FLAG_IDX);

	// Address and data are held until both are present
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr_i;
			end else if (wr_go) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end else if (wr_go) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bvalid_r <= 1'b0;
			bresp_r  <= TCC_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			unique case (wr_idx)
				TCC_VAL_LOW_IDX, TCC_VAL_HIGH_IDX, TCC_CONTROL_IDX,
				TCC_FLAG_IDX, TCC_PORT_IDX: bresp_r <= TCC_RESP_OKAY;
				default:                    bresp_r <= TCC_RESP_SLVERR;
			endcase
		end else if (s_axi_bready_i) begin
			bvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o  = bresp_r;

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	// Control: bits 7:6 are not stored and so read as zero
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			control_r <= TCC_CONTROL_RST;
		end else if (wr_ctrl) begin
			control_r <= w_data_r[5:0];
		end
	end

	// Capture beats a software write in the same cycle; no overrun bit
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			value_r <= 16'h0000;
		end else if (capture) begin
			value_r <= timer_one_count_i;
		end else if (wr_byte && wr_idx == TCC_VAL_LOW_IDX) begin
			value_r[7:0] <= w_data_r[7:0];
		end else if (wr_byte && wr_idx == TCC_VAL_HIGH_IDX) begin
			value_r[15:8] <= w_data_r[7:0];
		end
	end

	// Event flag: set wins over the write-one clear
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			flag_r <= 1'b0;
		end else if (capture || match) begin
			flag_r <= 1'b1;
		end else if (wr_flag && w_data_r[TCC_FLAG_BIT]) begin
			flag_r <= 1'b0;
		end
	end

	// Event enable and port configuration
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			enable_r <= 1'b0;
			port_r   <= TCC_PORT_RST;
		end else begin
			if (wr_flag) begin
				enable_r <= w_data_r[TCC_ENABLE_BIT];
			end
			if (wr_byte && wr_idx == TCC_PORT_IDX) begin
				port_r <= w_data_r[4:0];
			end
		end
	end

	assign ccp_event_flag_o   = flag_r;
	assign ccp_event_enable_o = enable_r;

	// ---------------------------------------------------------------
	// AXI4-Lite read channel
	// ---------------------------------------------------------------
	assign s_axi_arready_o = ~rvalid_r;
	assign rd_idx = s_axi_araddr_i[TCC_ADDR_W-1:2];

	// Read data registered at the address handshake
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= TCC_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_r <= 1'b1;
			rresp_r  <= TCC_RESP_OKAY;
			unique case (rd_idx)
				TCC_VAL_LOW_IDX:  rdata_r <= {24'h000000, value_r[7:0]};
				TCC_VAL_HIGH_IDX: rdata_r <= {24'h000000, value_r[15:8]};
				TCC_CONTROL_IDX:  rdata_r <= {26'h0, control_r};
				TCC_FLAG_IDX:     rdata_r <= {30'h0, enable_r, flag_r};
				TCC_PORT_IDX:     rdata_r <= {27'h0, port_r};
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= TCC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready_i) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rdata_o  = rdata_r;
	assign s_axi_rresp_o  = rresp_r;

endmodule // tcc_unit

// ==== bench/tcc_pin_model.sv ====
// Pad model: external signal source on the two mapped port pins
`timescale 1ns/1ps

module tcc_pin_model (
	// Clock
	input  wire logic       clk_i,
	// External source
	input  wire logic [1:0] drv_lvl_i,
	input  wire logic [1:0] drv_en_i,
	// Device side of the pads
	input  wire logic [1:0] dut_pin_i,
	input  wire logic [1:0] dut_oe_i,
	// Resolved pad level
	output      logic [1:0] pad_o
);
	logic [1:0] float_r;

	// A pad nobody drives toggles, so a stale level is never trusted
	always_ff @(posedge clk_i) begin
		float_r <= ~pad_o;
	end

	// Source only drives a pad that the device leaves as input
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (dut_oe_i[i]) begin
				pad_o[i] = dut_pin_i[i];
			end else if (drv_en_i[i]) begin
				pad_o[i] = drv_lvl_i[i];
			end else begin
				pad_o[i] = float_r[i];
			end
		end
	end
endmodule // tcc_pin_model

// ==== bench/tcc_unit_monitor.sv ====
// Concurrent checks on the capture/compare unit ports
`timescale 1ns/1ps

module tcc_unit_monitor
	import tcc_pkg::*;
(
	// Clock, reset and bus
	input wire logic                  clk_i,
	input wire logic                  reset_i,
	input wire logic                  s_axi_awvalid_i,
	input wire logic                  s_axi_awready_o,
	input wire logic [TCC_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic                  s_axi_wvalid_i,
	input wire logic                  s_axi_wready_o,
	input wire logic [31:0]           s_axi_wdata_i,
	input wire logic [3:0]            s_axi_wstrb_i,
	input wire logic                  s_axi_bvalid_o,
	input wire logic                  s_axi_arvalid_i,
	input wire logic                  s_axi_arready_o,
	input wire logic [TCC_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic                  s_axi_rvalid_o,
	input wire logic [31:0]           s_axi_rdata_o,
	input wire logic [1:0]            s_axi_rresp_o,
	// Timer, trigger and pins
	input wire logic [15:0]           timer_one_count_i,
	input wire logic                  timer_update_i,
	input wire logic                  timer_one_reset_o,
	input wire logic [1:0]            port_pin_o,
	input wire logic                  ccp_event_flag_o
);
	// ------------------------------------------------
	// Shadow of mode, value and port register
	// ------------------------------------------------
	logic [7:0]  a_q, d_q;
	logic        s_q, aw_t, w_t, go_r;
	logic [3:0]  mode_r;
	logic [15:0] val_r;
	logic [4:0]  port_r;
	wire         aw_hs = s_axi_awvalid_i && s_axi_awready_o;
	wire         w_hs  = s_axi_wvalid_i && s_axi_wready_o;

	// Apply a write one edge after both halves are taken, like the slave
	always_ff @(posedge clk_i) begin
		if (aw_hs) a_q <= s_axi_awaddr_i;
		if (w_hs) d_q <= s_axi_wdata_i[7:0];
		if (w_hs) s_q <= s_axi_wstrb_i[0];
		if (reset_i) begin
			{aw_t, w_t, go_r} <= 3'h0;
			{mode_r, val_r, port_r} <= {4'h0, 16'h0, 5'h03};
		end else begin
			aw_t <= (aw_t || aw_hs) && !go_r;
			w_t <= (w_t || w_hs) && !go_r;
			go_r <= (aw_t || aw_hs) && (w_t || w_hs) && !go_r;
			if (go_r && s_q) begin
				case (a_q)
					8'h54: val_r[7:0] <= d_q;
					8'h58: val_r[15:8] <= d_q;
					8'h5C: mode_r <= d_q[3:0];
					8'h64: port_r <= d_q[4:0];
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_wtake;
		aw_hs && w_hs;
	endsequence
	sequence s_hit(logic [3:0] md);
		mode_r == md && timer_update_i && timer_one_count_i == val_r;
	endsequence

	wr_answer_a: assert property (s_wtake |-> ##2 s_axi_bvalid_o)
		else $error("write response late");
	rd_ok_a: assert property (s_axi_arvalid_i && s_axi_arready_o &&
		s_axi_araddr_i inside {8'h54, 8'h58, 8'h5C, 8'h60, 8'h64}
		|=> s_axi_rvalid_o && s_axi_rresp_o == TCC_RESP_OKAY &&
		s_axi_rdata_o[31:8] == 24'h0)
		else $error("mapped read answer wrong");
	rd_unmap_a: assert property (s_axi_arvalid_i && s_axi_arready_o &&
		s_axi_araddr_i == 8'h70 |=> s_axi_rvalid_o &&
		s_axi_rresp_o == TCC_RESP_SLVERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read answer wrong");
	flag_clr_a: assert property ($fell(ccp_event_flag_o) |->
		$past(go_r) && a_q == 8'h60 && s_q && d_q[0])
		else $error("flag cleared without software");
	cmp_set_a: assert property (s_hit(4'h8) |=>
		port_pin_o[port_r[4]] && ccp_event_flag_o)
		else $error("compare set missed");
	cmp_clr_a: assert property (s_hit(4'h9) |=>
		!port_pin_o[port_r[4]] && ccp_event_flag_o)
		else $error("compare clear missed");
	flag_only_a: assert property (s_hit(4'hA) |=>
		ccp_event_flag_o && $stable(port_pin_o))
		else $error("flag-only compare wrong");
	spec_trig_a: assert property (s_hit(4'hB) |->
		##[1:2] timer_one_reset_o)
		else $error("special trigger missing");
	port_latch_a: assert property (mode_r[3:1] != 3'b100 |->
		port_pin_o == port_r[3:2])
		else $error("pin not from port latch");
endmodule // tcc_unit_monitor

bind tcc_unit tcc_unit_monitor u_mon (.*);

// ==== bench/tb_top.sv ====
// Self-checking bench for the timer capture/compare unit
`timescale 1ns/1ps

module tb_top
	import tcc_pkg::*;
;
	// ------------------------------------------------
	// Signals, named as the unit's ports
	// ------------------------------------------------
	localparam logic [1:0] OK = TCC_RESP_OKAY;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic        s_axi_arvalid_i, s_axi_rready_i;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i;
	logic [3:0]  s_axi_wstrb_i;
	logic [15:0] timer_one_count_i, v;
	logic        timer_update_i, adc_enable_i;
	logic [1:0]  lvl, den;
	wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	wire         s_axi_arready_o, s_axi_rvalid_o, ccp_event_flag_o;
	wire         ccp_event_enable_o, timer_one_reset_o, adc_start_o;
	wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o, duty_low_bits_o;
	wire  [1:0]  port_pin_i, port_pin_o, port_pin_oe_o;
	wire  [31:0] s_axi_rdata_o;
	int          err_count, compares, trig_cnt, adc_cnt, m, np;

	tcc_unit u_dut (.*);
	tcc_pin_model u_pad (.clk_i, .drv_lvl_i(lvl), .drv_en_i(den),
		.dut_pin_i(port_pin_o), .dut_oe_i(port_pin_oe_o), .pad_o(port_pin_i));

	// 50 MHz clock
	always #10 clk_i = ~clk_i;

	// Count one-cycle trigger pulses away from the sampling edge
	always @(negedge clk_i) begin
		if (timer_one_reset_o === 1'b1) trig_cnt++;
		if (adc_start_o === 1'b1) adc_cnt++;
	end

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	// Write: address and data offered together, each dropped when taken
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		bit aw, w, b;
		int n;
		{aw, w, b, n} = 0;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= {24'h0, d};
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		while (!b && n < 50) begin
			@(negedge clk_i);
			aw |= s_axi_awvalid_i && s_axi_awready_o;
			w |= s_axi_wvalid_i && s_axi_wready_o;
			b = s_axi_bvalid_o;
			if (b) chk(s_axi_bresp_o, er, "bresp");
			@(posedge clk_i);
			{s_axi_awvalid_i, s_axi_wvalid_i} <= {!aw, !w};
			n++;
		end
		s_axi_bready_i <= 1'b0;
		if (!b) chk(32'h0, 32'h1, "write timeout");
		// Let an edge pass so the next call never re-drives in this step
		@(posedge clk_i);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit t, r;
		int n;
		{t, r, n} = 0;
		s_axi_araddr_i <= a;
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
		while (!r && n < 50) begin
			@(negedge clk_i);
			t |= s_axi_arvalid_i && s_axi_arready_o;
			r = s_axi_rvalid_o;
			if (r) chk(s_axi_rdata_o, ed, "rdata");
			if (r) chk(s_axi_rresp_o, er, "rresp");
			@(posedge clk_i);
			s_axi_arvalid_i <= !t;
			n++;
		end
		s_axi_rready_i <= 1'b0;
		if (!r) chk(32'h0, 32'h1, "read timeout");
		@(posedge clk_i);
	endtask

	task rdv(input logic [15:0] x);
		rd(8'h54, {24'h0, x[7:0]}, OK);
		rd(8'h58, {24'h0, x[15:8]}, OK);
	endtask

	task pulse(input int i, input int n);
		repeat (n) begin
			lvl[i] <= 1'b0;
			repeat (4) @(posedge clk_i);
			lvl[i] <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
	endtask

	// Timer runs in the core clock domain, so it stays synchronous
	task tick();
		timer_one_count_i <= 16'h1230;
		timer_update_i <= 1'b1;
		repeat (8) begin
			@(posedge clk_i);
			timer_one_count_i <= timer_one_count_i + 16'h1;
		end
		timer_update_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task final_report();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------
	// Test sequence
	// ------------------------------------------------
	initial begin
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
		{s_axi_arvalid_i, s_axi_rready_i, timer_update_i} = 3'h0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
		{timer_one_count_i, adc_enable_i, s_axi_wstrb_i} = 21'hF;
		{lvl, den} = 4'hF;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rd(8'h5C, 32'h0, OK);
		rd(8'h64, 32'h3, OK);
		rd(8'h70, 32'h0, TCC_RESP_SLVERR);
		wr(8'h70, 8'h55, TCC_RESP_SLVERR);
		wr(8'h5C, 8'hFF, OK);
		rd(8'h5C, 32'h3F, OK);
		// Low lane off: the write is answered but leaves control alone
		s_axi_wstrb_i <= 4'hE;
		wr(8'h5C, 8'h00, OK);
		s_axi_wstrb_i <= 4'hF;
		chk(duty_low_bits_o, 32'h3, "duty bits");
		wr(8'h60, 8'h02, OK);
		chk(ccp_event_enable_o, 32'h1, "enable bit");
		// Every capture edge choice, then a second capture overwrites
		for (m = 4; m < 8; m++) begin
			np = (m == 6) ? 4 : (m == 7) ? 16 : 1;
			v = 16'hA500 + 16'(m);
			wr(8'h5C, 8'h00, OK);
			wr(8'h5C, 8'(m), OK);
			wr(8'h60, 8'h01, OK);
			timer_one_count_i <= v;
			pulse(0, np - 1);
			chk(ccp_event_flag_o, 32'h0, "early capture");
			pulse(0, 1);
			chk(ccp_event_flag_o, 32'h1, "capture flag");
			rdv(v);
			timer_one_count_i <= ~v;
			pulse(0, np);
			chk(ccp_event_flag_o, 32'h1, "flag held");
			rdv(~v);
		end
		// Direct prescaler switch keeps the count
		wr(8'h5C, 8'h00, OK);
		wr(8'h5C, 8'(TCC_MODE_CAP_4TH), OK);
		pulse(0, 2);
		wr(8'h5C, 8'(TCC_MODE_CAP_16TH), OK);
		wr(8'h60, 8'h01, OK);
		pulse(0, 13);
		chk(ccp_event_flag_o, 32'h0, "switch early");
		pulse(0, 1);
		chk(ccp_event_flag_o, 32'h1, "switch capture");
		// Alternate pin mapping
		wr(8'h64, 8'h13, OK);
		wr(8'h5C, 8'h00, OK);
		wr(8'h5C, 8'(TCC_MODE_CAP_RISE), OK);
		wr(8'h60, 8'h01, OK);
		pulse(0, 1);
		chk(ccp_event_flag_o, 32'h0, "unmapped pin");
		pulse(1, 1);
		chk(ccp_event_flag_o, 32'h1, "mapped pin");
		// Pin as output: port latch write makes a capture
		wr(8'h64, 8'h02, OK);
		chk(port_pin_oe_o, 32'h1, "pin drive");
		wr(8'h60, 8'h01, OK);
		wr(8'h64, 8'h06, OK);
		repeat (4) @(posedge clk_i);
		chk(ccp_event_flag_o, 32'h1, "port write capture");
		// Compare set, clear, set on a match at 0x1234
		wr(8'h64, 8'h02, OK);
		wr(8'h5C, 8'h00, OK);
		wr(8'h54, 8'h34, OK);
		wr(8'h58, 8'h12, OK);
		for (m = 0; m < 3; m++) begin
			wr(8'h5C, 8'((m == 1) ? TCC_MODE_CMP_CLR
			                      : TCC_MODE_CMP_SET), OK);
			wr(8'h60, 8'h01, OK);
			tick();
			chk(port_pin_o[0], 32'(m != 1), "compare pin");
			chk(ccp_event_flag_o, 32'h1, "compare flag");
		end
		wr(8'h5C, 8'h00, OK);
		wr(8'h5C, 8'(TCC_MODE_CMP_SET), OK);
		chk(port_pin_o[0], 32'h0, "latch cleared");
		rd(8'h64, 32'h02, OK);
		// Flag-only compare with the port latch high
		wr(8'h64, 8'h06, OK);
		wr(8'h5C, 8'(TCC_MODE_CMP_FLAG), OK);
		wr(8'h60, 8'h01, OK);
		tick();
		chk(ccp_event_flag_o, 32'h1, "flag only");
		chk(port_pin_o[0], 32'h1, "pin kept");
		// Special event, converter on then off
		adc_enable_i <= 1'b1;
		wr(8'h5C, 8'(TCC_MODE_CMP_SPEC), OK);
		tick();
		chk(trig_cnt, 32'h1, "timer reset");
		chk(adc_cnt, 32'h1, "conversion start");
		adc_enable_i <= 1'b0;
		tick();
		chk(trig_cnt, 32'h2, "timer reset");
		chk(adc_cnt, 32'h1, "conversion gated");
		final_report();
	end

	// Watchdog well beyond the fewer than a thousand cycles the tests take
	initial begin
		#200000;
		err_count++;
		final_report();
	end
endmodule // tb_top
